// [design/adcc_defines.svh]
// Constants for the converter control and result port
`ifndef ADCC_DEFINES_SVH
`define ADCC_DEFINES_SVH
// Result width and number of bit decisions
`define ADCC_RES_W 16
`define ADCC_BITS 5'h10
// Cycles per bit decision, upper and lower result bits
`define ADCC_STEP_MSB_CYC 3'h4
`define ADCC_STEP_LSB_CYC 3'h6
// Highest bit index decided with the longer step
`define ADCC_LSB_FIRST 4'h7
// Cycles per serial clock half period after conversion
`define ADCC_SER_HALF_CYC 3'h2
// Busy pulse length of the fast initialisation
`define ADCC_INIT_CYC 4'h8
// Conversions to discard after power up or power down
`define ADCC_WARMUP_CONV 8'h80
// Mask that turns offset binary into twos complement
`define ADCC_TWOS_FLIP 16'h8000
// Result buffer depth
`define ADCC_FIFO_DEPTH 16
// Synchronised pin vector layout
`define ADCC_PIN_W 13
`define ADCC_P_CNV 0
`define ADCC_P_RST 1
`define ADCC_P_PWDN 2
`define ADCC_P_CS 3
`define ADCC_P_RD 4
`define ADCC_P_SERSEL 5
`define ADCC_P_CLKSEL 6
`define ADCC_P_DURING 7
`define ADCC_P_SWAP 8
`define ADCC_P_CODING 9
`define ADCC_P_REDPWR 10
`define ADCC_P_SCLKINV 11
`define ADCC_P_SYNCINV 12
`endif

// [design/adcc_pkg.sv]
// Types shared by the converter control modules
`default_nettype none
`include "adcc_defines.svh"
package adcc_pkg;
    typedef enum logic [1:0] {ADCC_IDLE, ADCC_CONV, ADCC_INIT} adcc_state_t;

    typedef struct packed {
        logic [15:0] sh;
        logic [4:0] cnt;
        logic ph;
        logic act;
    } adcc_shift_st_t;

    typedef struct packed {
        logic [`ADCC_PIN_W-1:0] s1;
        logic [`ADCC_PIN_W-1:0] s2;
        logic cnv_d;
        logic rst_d;
        logic pwdn_d;
        adcc_state_t st;
        logic [3:0] idx;
        logic [2:0] step;
        logic [3:0] init_cnt;
        logic [7:0] warm;
        logic [15:0] held;
        logic [15:0] trial;
        logic [15:0] out;
        logic [2:0] div;
        logic busy;
        logic [15:0] data;
        logic data_oe_n;
        logic sdo;
        logic sclk;
        logic sync;
        logic ser_oe_n;
        logic low_pow;
        logic discard;
    } adcc_top_st_t;
endpackage : adcc_pkg
`default_nettype wire

// [design/adcc_fifo.sv]
// Result buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module adcc_fifo #(
    parameter int W = 16,
    parameter int DEPTH = 16
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic flush_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
    } adcc_fifo_st_t;
    adcc_fifo_st_t r;
    adcc_fifo_st_t n;
    logic push;
    logic pop;

    // Honest full and empty from the fill count
    assign in_ready_o = (r.cnt != (AW+1)'(DEPTH));
    assign out_valid_o = (r.cnt != '0);
    assign out_data_o = r.mem[r.rd];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    // Pointer and storage update
    always_comb begin
        n = r;
        if (flush_i) begin
            n.wr = '0;
            n.rd = '0;
            n.cnt = '0;
        end else begin
            if (push) begin
                n.mem[r.wr] = in_data_i;
                n.wr = r.wr + 1'b1;
            end
            if (pop) begin
                n.rd = r.rd + 1'b1;
            end
            n.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // State register
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end
endmodule : adcc_fifo
`default_nettype wire

// [design/adcc_shift.sv]
// Serial shifter that sends one result MSB first
`timescale 1ns/1ps
`default_nettype none
`include "adcc_defines.svh"
module adcc_shift
    import adcc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic abort_i,
    input wire logic load_i,
    input wire logic [15:0] word_i,
    input wire logic tick_i,
    output logic busy_o,
    output logic sclk_o,
    output logic sdo_o
);
    adcc_shift_st_t r;
    adcc_shift_st_t n;

    assign busy_o = r.act;
    assign sclk_o = r.ph;
    assign sdo_o = r.sh[15];

    // Two ticks per bit: clock rises, then falls and the next bit moves out
    always_comb begin
        n = r;
        if (abort_i) begin
            n.act = 1'b0;
            n.ph = 1'b0;
        end else if (load_i) begin
            n.sh = word_i;
            n.cnt = `ADCC_BITS;
            n.ph = 1'b0;
            n.act = 1'b1;
        end else if (r.act && tick_i) begin
            if (!r.ph) begin
                n.ph = 1'b1;
            end else begin
                n.ph = 1'b0;
                n.sh = {r.sh[14:0], 1'b0};
                n.cnt = r.cnt - 5'h01;
                if (r.cnt == 5'h01) begin
                    n.act = 1'b0;
                end
            end
        end
    end

    // State register
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    hold_valid_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        r.ph && !abort_i && !load_i |=> $stable(sdo_o) || !sclk_o)
        else $error("serial data moved while clock high");

    serial_len_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        load_i && !abort_i |=> r.act && r.cnt == 5'h10)
        else $error("serial word not sixteen bits");
endmodule : adcc_shift
`default_nettype wire

// [design/adcc_top.sv]
// Conversion control and result output port of a 16-bit converter
`timescale 1ns/1ps
`default_nettype none
`include "adcc_defines.svh"
module adcc_top
    import adcc_pkg::*;
(
    input wire logic CLOCK_I,
    input wire logic RST_N_I,
    input wire logic CONVERT_START_N_I,
    input wire logic RESET_I,
    input wire logic POWER_DOWN_I,
    input wire logic REDUCED_POWER_I,
    input wire logic CS_N_I,
    input wire logic RD_N_I,
    input wire logic CODING_SELECT_I,
    input wire logic SERIAL_PARALLEL_SELECT_I,
    input wire logic BYTE_LANE_SWAP_I,
    input wire logic CLOCK_SOURCE_SELECT_I,
    input wire logic READ_DURING_CONVERT_SELECT_I,
    input wire logic SCLK_INVERT_I,
    input wire logic SYNC_INVERT_I,
    input wire logic [15:0] SAMPLE_I,
    output logic BUSY_O,
    output logic [15:0] DATA_O,
    output logic DATA_OE_N_O,
    output logic SERIAL_DATA_O,
    output logic SCLK_O,
    output logic SYNC_O,
    output logic SERIAL_OE_N_O,
    output logic LOW_POWER_O,
    output logic DISCARD_O
);
    adcc_top_st_t r;
    adcc_top_st_t n;
    logic [`ADCC_PIN_W-1:0] pins_w;
    logic cnv_n_s;
    logic rst_s;
    logic pwdn_s;
    logic cs_n_s;
    logic rd_n_s;
    logic sersel_s;
    logic clksel_s;
    logic during_s;
    logic swap_s;
    logic coding_s;
    logic redpwr_s;
    logic sclk_inv_s;
    logic sync_inv_s;
    logic cnv_fall_w;
    logic rst_fall_w;
    logic [15:0] bit_w;
    logic [15:0] trial_w;
    logic [15:0] decided_w;
    logic step_end_w;
    logic conv_done_w;
    logic start_w;
    logic after_w;
    logic during_w;
    logic [15:0] push_data_w;
    logic fifo_in_ready_w;
    logic fifo_out_valid_w;
    logic fifo_out_ready_w;
    logic [15:0] fifo_data_w;
    logic pop_w;
    logic sh_load_w;
    logic [15:0] sh_word_w;
    logic tick_w;
    logic sh_busy_w;
    logic sh_sclk_w;
    logic sh_sdo_w;
    logic [7:0] out_hi_w;
    logic [7:0] out_lo_w;

    // Pins gathered for the two-stage synchroniser
    assign pins_w = {SYNC_INVERT_I, SCLK_INVERT_I, REDUCED_POWER_I, CODING_SELECT_I,
                     BYTE_LANE_SWAP_I, READ_DURING_CONVERT_SELECT_I, CLOCK_SOURCE_SELECT_I,
                     SERIAL_PARALLEL_SELECT_I, RD_N_I, CS_N_I, POWER_DOWN_I, RESET_I,
                     CONVERT_START_N_I};

    // Synchronised pin levels, all taken from the second stage
    assign cnv_n_s = r.s2[`ADCC_P_CNV];
    assign rst_s = r.s2[`ADCC_P_RST];
    assign pwdn_s = r.s2[`ADCC_P_PWDN];
    assign cs_n_s = r.s2[`ADCC_P_CS];
    assign rd_n_s = r.s2[`ADCC_P_RD];
    assign sersel_s = r.s2[`ADCC_P_SERSEL];
    assign clksel_s = r.s2[`ADCC_P_CLKSEL];
    assign during_s = r.s2[`ADCC_P_DURING];
    assign swap_s = r.s2[`ADCC_P_SWAP];
    assign coding_s = r.s2[`ADCC_P_CODING];
    assign redpwr_s = r.s2[`ADCC_P_REDPWR];
    assign sclk_inv_s = r.s2[`ADCC_P_SCLKINV];
    assign sync_inv_s = r.s2[`ADCC_P_SYNCINV];

    // Edge detection on convert-start and the reset pin
    assign cnv_fall_w = r.cnv_d && !cnv_n_s;
    assign rst_fall_w = r.rst_d && !rst_s;

    // One bit decision: keep the trial bit if it does not exceed the held sample
    assign bit_w = 16'h0001 << r.idx;
    assign trial_w = r.trial | bit_w;
    assign decided_w = (trial_w <= r.held) ? trial_w : r.trial;
    assign step_end_w = (r.step == 3'h0);
    assign conv_done_w = (r.st == ADCC_CONV) && step_end_w && (r.idx == 4'h0);

    assign push_data_w = coding_s ? decided_w : (decided_w ^ `ADCC_TWOS_FLIP);

    assign start_w = (r.st == ADCC_IDLE) && cnv_fall_w && !pwdn_s && !rst_s && fifo_in_ready_w;

    assign after_w = sersel_s && !clksel_s && !during_s;
    assign during_w = sersel_s && !clksel_s && during_s;

    // Buffer drains into the output register unless a word is being shifted or the reset pin is held
    assign fifo_out_ready_w = !sh_busy_w && !rst_s;
    assign pop_w = fifo_out_valid_w && fifo_out_ready_w;

    assign sh_load_w = (after_w && pop_w) || (during_w && start_w);
    assign sh_word_w = after_w ? fifo_data_w : r.out;

    assign tick_w = during_w ? ((r.st == ADCC_CONV) &&
                                (step_end_w || r.step == `ADCC_SER_HALF_CYC))
                             : (r.div == 3'h0);

    assign out_hi_w = r.out[15:8];
    assign out_lo_w = r.out[7:0];

    adcc_fifo #(
        .W(`ADCC_RES_W),
        .DEPTH(`ADCC_FIFO_DEPTH)
    ) u_fifo (
        .clk_i(CLOCK_I),
        .rst_n_i(RST_N_I),
        .flush_i(rst_s),
        .in_valid_i(conv_done_w),
        .in_ready_o(fifo_in_ready_w),
        .in_data_i(push_data_w),
        .out_valid_o(fifo_out_valid_w),
        .out_ready_i(fifo_out_ready_w),
        .out_data_o(fifo_data_w)
    );

    adcc_shift u_shift (
        .clk_i(CLOCK_I),
        .rst_n_i(RST_N_I),
        .abort_i(rst_s),
        .load_i(sh_load_w),
        .word_i(sh_word_w),
        .tick_i(tick_w),
        .busy_o(sh_busy_w),
        .sclk_o(sh_sclk_w),
        .sdo_o(sh_sdo_w)
    );

    // Next state of the whole block
    always_comb begin
        n = r;
        n.s1 = pins_w;
        n.s2 = r.s1;
        n.cnv_d = cnv_n_s;
        n.rst_d = rst_s;
        n.pwdn_d = pwdn_s;
        // Serial clock divider for read after conversion
        if (!sh_busy_w || r.div == 3'h0) begin
            n.div = `ADCC_SER_HALF_CYC - 3'h1;
        end else begin
            n.div = r.div - 3'h1;
        end
        case (r.st)
            ADCC_IDLE: begin
                if (start_w) begin
                    n.st = ADCC_CONV;
                    n.held = SAMPLE_I;
                    n.trial = '0;
                    n.idx = 4'hf;
                    n.step = `ADCC_STEP_MSB_CYC - 3'h1;
                end
            end
            ADCC_CONV: begin
                if (step_end_w) begin
                    n.trial = decided_w;
                    if (r.idx == 4'h0) begin
                        n.st = ADCC_IDLE;
                        if (r.warm != `ADCC_WARMUP_CONV) begin
                            n.warm = r.warm + 8'h01;
                        end
                    end else begin
                        n.idx = r.idx - 4'h1;
                        if ((r.idx - 4'h1) <= `ADCC_LSB_FIRST) begin
                            n.step = `ADCC_STEP_LSB_CYC - 3'h1;
                        end else begin
                            n.step = `ADCC_STEP_MSB_CYC - 3'h1;
                        end
                    end
                end else begin
                    n.step = r.step - 3'h1;
                end
            end
            ADCC_INIT: begin
                n.init_cnt = r.init_cnt - 4'h1;
                if (r.init_cnt == 4'h1) begin
                    n.st = ADCC_IDLE;
                end
            end
            default: begin
                n.st = ADCC_IDLE;
            end
        endcase
        // Latest result taken from the buffer
        if (pop_w) begin
            n.out = fifo_data_w;
        end
        if (rst_s) begin
            n.st = ADCC_IDLE;
        end
        if (rst_fall_w) begin
            n.st = ADCC_INIT;
            n.init_cnt = `ADCC_INIT_CYC;
            n.out = '0;
            n.warm = `ADCC_WARMUP_CONV;
        end
        if (r.pwdn_d && !pwdn_s) begin
            n.warm = '0;
        end
        n.discard = (n.warm != `ADCC_WARMUP_CONV);
        // busy follows conversion; held while shifting
        // The push cycle counts too, so busy has no one-cycle gap before the pop
        n.busy = (n.st != ADCC_IDLE) ||
                 (after_w && (sh_busy_w || fifo_out_valid_w || conv_done_w));
        n.low_pow = (redpwr_s || pwdn_s) && (n.st == ADCC_IDLE);
        n.data = swap_s ? {out_lo_w, out_hi_w} : r.out;
        n.data_oe_n = rst_s || cs_n_s || rd_n_s || sersel_s;
        n.ser_oe_n = rst_s || cs_n_s || rd_n_s || !sersel_s || clksel_s;
        n.sdo = sh_sdo_w;
        n.sclk = sh_sclk_w ^ sclk_inv_s;
        n.sync = sh_busy_w ^ sync_inv_s;
    end

    // State register
    always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            r <= '0;
            r.data_oe_n <= 1'b1;
            r.ser_oe_n <= 1'b1;
            r.discard <= 1'b1;
        end else begin
            r <= n;
        end
    end

    // Outputs straight from the state register
    assign BUSY_O = r.busy;
    assign DATA_O = r.data;
    assign DATA_OE_N_O = r.data_oe_n;
    assign SERIAL_DATA_O = r.sdo;
    assign SCLK_O = r.sclk;
    assign SYNC_O = r.sync;
    assign SERIAL_OE_N_O = r.ser_oe_n;
    assign LOW_POWER_O = r.low_pow;
    assign DISCARD_O = r.discard;

    default clocking adcc_cb @(posedge CLOCK_I);
    endclocking
    default disable iff (!RST_N_I);

    sequence init_busy_s;
        BUSY_O && r.st == ADCC_INIT [*8];
    endsequence

    conv_start_a: assert property (
        start_w |=> r.st == ADCC_CONV && BUSY_O && r.idx == 4'hf)
        else $error("convert-start edge did not launch");

    no_abort_a: assert property (
        r.st == ADCC_CONV && !rst_s && !conv_done_w |=> r.st == ADCC_CONV)
        else $error("conversion left early");

    reset_abort_a: assert property (
        rst_s |=> r.st != ADCC_CONV && DATA_OE_N_O && SERIAL_OE_N_O)
        else $error("reset did not abort or float bus");

    bus_gate_a: assert property (
        cs_n_s || rd_n_s |=> DATA_OE_N_O && SERIAL_OE_N_O)
        else $error("outputs driven while deselected");

    lane_swap_a: assert property (
        swap_s |=> DATA_O == {$past(out_lo_w), $past(out_hi_w)})
        else $error("byte lanes not exchanged");

    coding_a: assert property (
        conv_done_w |-> push_data_w == (coding_s ? r.held : (r.held ^ `ADCC_TWOS_FLIP)))
        else $error("result coding wrong");

    busy_after_a: assert property (
        after_w && (sh_busy_w || conv_done_w) |=> BUSY_O)
        else $error("busy fell before serial word done");

    busy_fall_a: assert property (
        conv_done_w && !after_w && !rst_s |=> !BUSY_O ##1 !BUSY_O || r.st == ADCC_CONV)
        else $error("busy did not fall at result");

    low_power_a: assert property (
        conv_done_w && redpwr_s && !rst_s |=> LOW_POWER_O)
        else $error("low current state not entered");

    init_pulse_a: assert property (
        rst_fall_w |=> init_busy_s ##1 !BUSY_O || rst_s)
        else $error("reset release busy pulse wrong");
endmodule : adcc_top
`default_nettype wire

// [tb/adcc_host.sv]
// Host model that receives serial result words from the port
`timescale 1ns/1ps
`default_nettype none
module adcc_host (
    input wire logic clk_i,
    input wire logic sclk_i,
    input wire logic sdo_i,
    input wire logic sync_i,
    input wire logic sclk_inv_i,
    input wire logic sync_inv_i,
    input wire logic oe_n_i,
    output logic [15:0] word_o,
    output logic [4:0] nbits_o
);
    logic sclk_d;
    logic sync_d;
    logic sc;
    logic sy;
    // Undo the configured polarities
    assign sc = sclk_i ^ sclk_inv_i;
    assign sy = sync_i ^ sync_inv_i;
    initial begin
        word_o = 16'h0000;
        nbits_o = 5'h00;
        sclk_d = 1'b0;
        sync_d = 1'b0;
    end
    // shift in MSB first on each rising serial clock
    always @(posedge clk_i) begin
        sclk_d <= sc;
        sync_d <= sy;
        if (!oe_n_i && sc && !sclk_d) begin
            word_o <= {word_o[14:0], sdo_i};
            nbits_o <= (sy && !sync_d) ? 5'h01 : nbits_o + 5'h01;
        end else if (!oe_n_i && sy && !sync_d) begin
            nbits_o <= 5'h00;
        end
    end
endmodule : adcc_host
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking bench for the converter control and result port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import adcc_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cnv_n = 1'b1;
    logic dev_rst = 1'b0;
    logic pwdn = 1'b0;
    logic redpwr = 1'b0;
    logic cs_n = 1'b0;
    logic rd_n = 1'b0;
    logic coding = 1'b1;
    logic ser = 1'b0;
    logic swap = 1'b0;
    logic clksel = 1'b0;
    logic during = 1'b0;
    logic sinv = 1'b0;
    logic yinv = 1'b0;
    logic [15:0] sample = 16'h0000;
    logic busy, sdo, sclk, sync, ser_oe_n, low_pow, discard, data_oe_n;
    logic [15:0] data;
    logic [15:0] hword;
    logic [4:0] hbits;
    int n_mismatch = 0;
    int tests_run = 0;
    int n;
    adcc_top adcc_top_i (.CLOCK_I(clk), .RST_N_I(rst_n), .CONVERT_START_N_I(cnv_n),
        .RESET_I(dev_rst), .POWER_DOWN_I(pwdn), .REDUCED_POWER_I(redpwr), .CS_N_I(cs_n),
        .RD_N_I(rd_n), .CODING_SELECT_I(coding), .SERIAL_PARALLEL_SELECT_I(ser),
        .BYTE_LANE_SWAP_I(swap), .CLOCK_SOURCE_SELECT_I(clksel),
        .READ_DURING_CONVERT_SELECT_I(during), .SCLK_INVERT_I(sinv),
        .SYNC_INVERT_I(yinv), .SAMPLE_I(sample), .BUSY_O(busy), .DATA_O(data),
        .DATA_OE_N_O(data_oe_n), .SERIAL_DATA_O(sdo), .SCLK_O(sclk), .SYNC_O(sync),
        .SERIAL_OE_N_O(ser_oe_n), .LOW_POWER_O(low_pow), .DISCARD_O(discard));
    adcc_host adcc_host_i (.clk_i(clk), .sclk_i(sclk), .sdo_i(sdo), .sync_i(sync),
        .sclk_inv_i(sinv), .sync_inv_i(yinv), .oe_n_i(ser_oe_n), .word_o(hword),
        .nbits_o(hbits));
    // Clock of 5 ns period
    initial begin
        forever #2.5 clk = ~clk;
    end
    // Compares one value and counts the outcome
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Waits for busy, counts its high cycles, and handles the start pin meanwhile
    task automatic wait_busy(input bit hit, output int cnt);
        int w;
        cnt = 0;
        w = 0;
        while (busy !== 1'b1 && w < 20) begin
            @(negedge clk);
            w++;
        end
        while (busy === 1'b1 && cnt < 400) begin
            cnt++;
            if (cnt == 4) cnv_n = 1'b1;
            if (cnt == 10 && hit) begin
                cnv_n = 1'b0;
                pwdn = 1'b1;
            end
            @(negedge clk);
        end
        cnv_n = 1'b1;
    endtask : wait_busy
    // Starts one conversion of the given sample
    task automatic convert(input logic [15:0] s, input bit hit, output int cnt);
        @(negedge clk);
        sample = s;
        cnv_n = 1'b0;
        wait_busy(hit, cnt);
        repeat (4) @(negedge clk);
    endtask : convert
    // Device reset aborts a conversion, then runs the fast initialisation
    task automatic t_reset;
        @(negedge clk);
        cnv_n = 1'b0;
        repeat (8) @(negedge clk);
        dev_rst = 1'b1;
        repeat (5) @(negedge clk);
        chk("busy in reset", 16'h0000, {15'h0000, busy});
        chk("bus float in reset", 16'h0001, {15'h0000, data_oe_n});
        cnv_n = 1'b1;
        @(negedge clk);
        dev_rst = 1'b0;
        // the host waits for the busy pulse to end
        wait_busy(1'b0, n);
        chk("init busy cycles", 16'h0008, n[15:0]);
        repeat (3) @(negedge clk);
        chk("bus after init", 16'h0000, data);
        chk("discard after init", 16'h0000, {15'h0000, discard});
        $display("test reset done");
    endtask : t_reset
    // Parallel results, coding, lanes and output enables
    task automatic t_par;
        convert(16'ha5c3, 1'b0, n);
        chk("busy cycles", 16'h0050, n[15:0]);
        chk("binary result", 16'ha5c3, data);
        chk("bus driven", 16'h0000, {15'h0000, data_oe_n});
        coding = 1'b0;
        swap = 1'b1;
        cs_n = 1'b1;
        convert(16'h1234, 1'b0, n);
        chk("float with cs high", 16'h0001, {15'h0000, data_oe_n});
        chk("start with cs high", 16'h0050, n[15:0]);
        cs_n = 1'b0;
        repeat (3) @(negedge clk);
        chk("swapped twos result", 16'h3492, data);
        rd_n = 1'b1;
        repeat (3) @(negedge clk);
        chk("float with rd high", 16'h0001, {15'h0000, data_oe_n});
        rd_n = 1'b0;
        swap = 1'b0;
        coding = 1'b1;
        $display("test parallel done");
    endtask : t_par
    // Start edge and power down inside a conversion are ignored
    task automatic t_abort;
        convert(16'h4321, 1'b1, n);
        chk("busy with late edge", 16'h0050, n[15:0]);
        chk("result kept", 16'h4321, data);
        convert(16'h1111, 1'b0, n);
        chk("start in power down", 16'h0000, n[15:0]);
        pwdn = 1'b0;
        repeat (4) @(negedge clk);
        chk("warm-up after power down", 16'h0001, {15'h0000, discard});
        $display("test abort done");
    endtask : t_abort
    // Master serial read after and during conversion, inverted polarities first
    task automatic t_serial;
        ser = 1'b1;
        sinv = 1'b1;
        yinv = 1'b1;
        convert(16'hc35a, 1'b0, n);
        chk("busy covers shift", 16'h0001, {15'h0000, n >= 144});
        chk("serial after word", 16'hc35a, hword);
        chk("serial after bits", 16'h0010, {11'h000, hbits});
        sinv = 1'b0;
        yinv = 1'b0;
        during = 1'b1;
        convert(16'h0f0f, 1'b0, n);
        chk("busy during mode", 16'h0050, n[15:0]);
        chk("previous word", 16'hc35a, hword);
        chk("during bits", 16'h0010, {11'h000, hbits});
        convert(16'h7001, 1'b0, n);
        chk("next previous word", 16'h0f0f, hword);
        clksel = 1'b1;
        repeat (4) @(negedge clk);
        chk("serial float ext clock", 16'h0001, {15'h0000, ser_oe_n});
        clksel = 1'b0;
        during = 1'b0;
        ser = 1'b0;
        $display("test serial done");
    endtask : t_serial
    // Reduced power drops current after conversion, bus stays live
    task automatic t_lowpow;
        redpwr = 1'b1;
        convert(16'h00ff, 1'b0, n);
        chk("low power idle", 16'h0001, {15'h0000, low_pow});
        chk("bus live", 16'h00ff, data);
        redpwr = 1'b0;
        repeat (4) @(negedge clk);
        chk("full power", 16'h0000, {15'h0000, low_pow});
        $display("test low power done");
    endtask : t_lowpow
    // Prints the counts and the verdict
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run
    // Main sequence
    initial begin
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        t_reset();
        t_par();
        t_abort();
        t_reset();
        t_serial();
        t_lowpow();
        complete_run();
    end
    // Watchdog
    initial begin
        #200000;
        n_mismatch++;
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
